// [hw/t2ar_defines.svh]
// Constants for the auto-reload up-counting timer: widths, register
// offsets, field positions, reset values and the prescale count.
// Assumes inclusion by bare name from the package and the design files.
`ifndef T2AR_DEFINES_SVH
`define T2AR_DEFINES_SVH

`define T2AR_ADDR_W 4
`define T2AR_DATA_W 16
`define T2AR_CNT_W 16
`define T2AR_PRE_W 4

// Peripheral clocks per count step; the prescaler is always in use
`define T2AR_PRESCALE_DIV 12

`define T2AR_OFF_CTRL 4'h0
`define T2AR_OFF_MODE 4'h1
`define T2AR_OFF_RELOAD 4'h2
`define T2AR_OFF_COUNT 4'h3
`define T2AR_OFF_STATUS 4'h4
`define T2AR_OFF_MASK 4'h5
`define T2AR_OFF_STATE 4'h6

`define T2AR_CTRL_RUN_BIT 0
`define T2AR_CTRL_CPSEL_BIT 1
`define T2AR_CTRL_EXTEN_BIT 2

`define T2AR_MODE_UPDOWN_BIT 0
`define T2AR_MODE_TRIGEDGE_BIT 1
`define T2AR_MODE_HWEN_BIT 2
`define T2AR_MODE_HWEDGE_BIT 3

`define T2AR_FLAG_OVF_BIT 0
`define T2AR_FLAG_EXT_BIT 1

`define T2AR_STATE_RUN_BIT 0
`define T2AR_STATE_PIN_BIT 1
`define T2AR_STATE_PRE_LSB 4

`define T2AR_CNT_RST 16'h0000
`define T2AR_RELOAD_RST 16'h0000
`define T2AR_CNT_MAX 16'hFFFF
`define T2AR_DATA_ZERO 16'h0000

`endif

// [hw/t2ar_pkg.sv]
// Types shared by the timer and its bus master.
// Assumes the defines header sits beside it on the include path.
`include "t2ar_defines.svh"

package t2ar_pkg;

  typedef logic [`T2AR_ADDR_W-1:0] t2ar_addr_t;
  typedef logic [`T2AR_DATA_W-1:0] t2ar_data_t;
  typedef logic [`T2AR_CNT_W-1:0] t2ar_cnt_t;
  typedef logic [`T2AR_PRE_W-1:0] t2ar_pre_t;

  typedef struct packed {
    t2ar_addr_t addr;
    t2ar_data_t wdata;
    logic wr;
    logic rd;
  } t2ar_bus_req_s;

  typedef struct packed {
    logic ext_en;
    logic cp_sel;
    logic run;
  } t2ar_ctrl_s;

  typedef struct packed {
    logic hw_edge_rise;
    logic hw_en;
    logic trig_edge_rise;
    logic updown;
  } t2ar_mode_s;

  typedef struct packed {
    logic ext;
    logic ovf;
  } t2ar_flags_s;

endpackage

// [hw/t2ar_edge.sv]
// Edge finder for a pin that is synchronous to the clock.
// Compares the present level with the sample held from the cycle before.
`timescale 1ns/1ns
`default_nettype none

module t2ar_edge (
  input wire logic sys_clk, // Peripheral clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic pin_in, // Pin level, synchronous
  output logic rise, // Low then high
  output logic fall // High then low
);

  logic last_ff;
  logic primed_ff;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_ff <= 1'b0;
      primed_ff <= 1'b0;
    end else begin
      last_ff <= pin_in;
      primed_ff <= 1'b1;
    end
  end

  // No edge before a first valid sample exists
  assign rise = primed_ff & ~last_ff & pin_in;
  assign fall = primed_ff & last_ff & ~pin_in;

endmodule

`default_nettype wire

// [hw/t2ar_timer.sv]
// Sixteen-bit auto-reload up-counting timer with trigger pin, flags and
// a small register port.
// Assumes a bus master that keeps strobes one cycle long and a trigger
// pin already synchronous to sys_clk.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "t2ar_defines.svh"

module t2ar_timer
  import t2ar_pkg::*;
(
  input wire logic sys_clk, // Peripheral clock, 100 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire t2ar_pkg::t2ar_bus_req_s bus_req, // Register request
  output t2ar_pkg::t2ar_data_t bus_rdata, // Read data, next cycle
  input wire logic trigger_input_pin, // Trigger pin level
  output logic irq // Level interrupt request
);

  import t2ar_pkg::*;

  localparam t2ar_pre_t PRE_LAST = t2ar_pre_t'(`T2AR_PRESCALE_DIV - 1);

  // Register state
  t2ar_ctrl_s ctrl_ff;
  t2ar_mode_s mode_ff;
  t2ar_cnt_t reload_value_register_ff;
  t2ar_cnt_t count_ff;
  t2ar_flags_s status_ff;
  t2ar_flags_s mask_ff;
  t2ar_pre_t pre_ff;
  t2ar_data_t rdata_ff;

  // Next values
  t2ar_cnt_t nxt_count;
  t2ar_pre_t nxt_pre;
  t2ar_flags_s nxt_status;
  t2ar_data_t nxt_rdata;

  // Decoded accesses
  logic wr_ctrl;
  logic wr_mode;
  logic wr_reload;
  logic wr_count;
  logic wr_status;
  logic wr_mask;

  // Pin events
  logic pin_rise;
  logic pin_fall;
  logic start_edge;
  logic trig_edge;
  logic start_now;
  logic pin_reload;

  // Counting events
  logic tick;
  logic at_max;
  logic ovf_event;
  logic ext_event;

  // Aliases of the documented control bits and status flags
  logic run_control_bit;
  logic capture_reload_select;
  logic external_enable;
  logic hw_start_enable;
  logic hw_start_edge_select;
  logic trigger_edge_select;
  logic updown_enable;
  logic overflow_flag;
  logic external_flag;

  assign run_control_bit = ctrl_ff.run;
  assign capture_reload_select = ctrl_ff.cp_sel;
  assign external_enable = ctrl_ff.ext_en;
  assign hw_start_enable = mode_ff.hw_en;
  assign hw_start_edge_select = mode_ff.hw_edge_rise;
  assign trigger_edge_select = mode_ff.trig_edge_rise;
  assign updown_enable = mode_ff.updown;
  assign overflow_flag = status_ff.ovf;
  assign external_flag = status_ff.ext;

  // ------------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------------

  always_comb begin
    wr_ctrl = 1'b0;
    wr_mode = 1'b0;
    wr_reload = 1'b0;
    wr_count = 1'b0;
    wr_status = 1'b0;
    wr_mask = 1'b0;
    if (bus_req.wr) begin
      case (bus_req.addr)
        `T2AR_OFF_CTRL: wr_ctrl = 1'b1;
        `T2AR_OFF_MODE: wr_mode = 1'b1;
        `T2AR_OFF_RELOAD: wr_reload = 1'b1;
        `T2AR_OFF_COUNT: wr_count = 1'b1;
        `T2AR_OFF_STATUS: wr_status = 1'b1;
        `T2AR_OFF_MASK: wr_mask = 1'b1;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Trigger pin edges
  // ------------------------------------------------------------------

  t2ar_edge u_pin_edge (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin_in(trigger_input_pin),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // Hardware start edge, polarity from the start edge select
  assign start_edge = hw_start_edge_select ? pin_rise : pin_fall;

  // Reload edge, polarity from the trigger edge select
  assign trig_edge = trigger_edge_select ? pin_rise : pin_fall;

  // Start only from the stopped state
  assign start_now = hw_start_enable & ~run_control_bit & start_edge;

  // The starting edge itself never reloads
  assign pin_reload = external_enable & ~capture_reload_select
                      & trig_edge & ~start_now;

  // ------------------------------------------------------------------
  // Control, mode and reload registers
  // ------------------------------------------------------------------

  // Run bit: hardware may only set it, a start wins over a clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= '0;
    end else begin
      if (start_now) begin
        ctrl_ff.run <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_ff.run <= bus_req.wdata[`T2AR_CTRL_RUN_BIT];
      end
      if (wr_ctrl) begin
        ctrl_ff.cp_sel <= bus_req.wdata[`T2AR_CTRL_CPSEL_BIT];
        ctrl_ff.ext_en <= bus_req.wdata[`T2AR_CTRL_EXTEN_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_ff <= '0;
    end else if (wr_mode) begin
      mode_ff.updown <= bus_req.wdata[`T2AR_MODE_UPDOWN_BIT];
      mode_ff.trig_edge_rise <= bus_req.wdata[`T2AR_MODE_TRIGEDGE_BIT];
      mode_ff.hw_en <= bus_req.wdata[`T2AR_MODE_HWEN_BIT];
      mode_ff.hw_edge_rise <= bus_req.wdata[`T2AR_MODE_HWEDGE_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reload_value_register_ff <= `T2AR_RELOAD_RST;
    end else if (wr_reload) begin
      reload_value_register_ff <= bus_req.wdata[`T2AR_CNT_W-1:0];
    end
  end

  // ------------------------------------------------------------------
  // Prescaler
  // ------------------------------------------------------------------

  always_comb begin
    if (!run_control_bit) begin
      nxt_pre = '0;
    end else if (pre_ff == PRE_LAST) begin
      nxt_pre = '0;
    end else begin
      nxt_pre = pre_ff + t2ar_pre_t'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= nxt_pre;
    end
  end

  // One step every twelfth clock of a run
  assign tick = run_control_bit & (pre_ff == PRE_LAST);

  // ------------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------------

  assign at_max = (count_ff == `T2AR_CNT_MAX);
  assign ovf_event = tick & at_max;

  // Direction bit is never looked at: the count only rises
  always_comb begin
    nxt_count = count_ff;
    if (pin_reload) begin
      nxt_count = reload_value_register_ff;
    end else if (ovf_event) begin
      nxt_count = reload_value_register_ff;
    end else if (tick) begin
      nxt_count = count_ff + t2ar_cnt_t'(1);
    end else if (wr_count) begin
      nxt_count = bus_req.wdata[`T2AR_CNT_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_ff <= `T2AR_CNT_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // ------------------------------------------------------------------
  // Flags and interrupt
  // ------------------------------------------------------------------

  assign ext_event = pin_reload | (start_now & external_enable);

  // Write one to clear; a new event in the same cycle keeps the flag
  always_comb begin
    nxt_status = status_ff;
    if (wr_status) begin
      if (bus_req.wdata[`T2AR_FLAG_OVF_BIT]) begin
        nxt_status.ovf = 1'b0;
      end
      if (bus_req.wdata[`T2AR_FLAG_EXT_BIT]) begin
        nxt_status.ext = 1'b0;
      end
    end
    if (ovf_event) begin
      nxt_status.ovf = 1'b1;
    end
    if (ext_event) begin
      nxt_status.ext = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_ff <= '0;
    end else begin
      status_ff <= nxt_status;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_ff <= '0;
    end else if (wr_mask) begin
      mask_ff.ovf <= bus_req.wdata[`T2AR_FLAG_OVF_BIT];
      mask_ff.ext <= bus_req.wdata[`T2AR_FLAG_EXT_BIT];
    end
  end

  // Follows the flag in the cycle it is set
  assign irq = |(status_ff & mask_ff);

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------

  always_comb begin
    nxt_rdata = `T2AR_DATA_ZERO;
    if (bus_req.rd) begin
      case (bus_req.addr)
        `T2AR_OFF_CTRL: begin
          nxt_rdata[`T2AR_CTRL_RUN_BIT] = run_control_bit;
          nxt_rdata[`T2AR_CTRL_CPSEL_BIT] = capture_reload_select;
          nxt_rdata[`T2AR_CTRL_EXTEN_BIT] = external_enable;
        end
        `T2AR_OFF_MODE: begin
          nxt_rdata[`T2AR_MODE_UPDOWN_BIT] = updown_enable;
          nxt_rdata[`T2AR_MODE_TRIGEDGE_BIT] = trigger_edge_select;
          nxt_rdata[`T2AR_MODE_HWEN_BIT] = hw_start_enable;
          nxt_rdata[`T2AR_MODE_HWEDGE_BIT] = hw_start_edge_select;
        end
        `T2AR_OFF_RELOAD: begin
          nxt_rdata[`T2AR_CNT_W-1:0] = reload_value_register_ff;
        end
        `T2AR_OFF_COUNT: begin
          nxt_rdata[`T2AR_CNT_W-1:0] = count_ff;
        end
        `T2AR_OFF_STATUS: begin
          nxt_rdata[`T2AR_FLAG_OVF_BIT] = overflow_flag;
          nxt_rdata[`T2AR_FLAG_EXT_BIT] = external_flag;
        end
        `T2AR_OFF_MASK: begin
          nxt_rdata[`T2AR_FLAG_OVF_BIT] = mask_ff.ovf;
          nxt_rdata[`T2AR_FLAG_EXT_BIT] = mask_ff.ext;
        end
        `T2AR_OFF_STATE: begin
          nxt_rdata[`T2AR_STATE_RUN_BIT] = run_control_bit;
          nxt_rdata[`T2AR_STATE_PIN_BIT] = trigger_input_pin;
          nxt_rdata[`T2AR_STATE_PRE_LSB +: `T2AR_PRE_W] = pre_ff;
        end
        default: begin
          nxt_rdata = `T2AR_DATA_ZERO;
        end
      endcase
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= `T2AR_DATA_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign bus_rdata = rdata_ff;

endmodule

`default_nettype wire

// [sim/t2ar_timer_sva.sv]
// Port checker for the auto-reload timer, bound to t2ar_timer.
// Assumes registers change only through the bus and the trigger pin.
`timescale 1ns/1ns
`default_nettype none

module t2ar_timer_chk
  import t2ar_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic arst_n, // Reset, active low
  input wire t2ar_pkg::t2ar_bus_req_s bus_req, // Register request
  input wire t2ar_pkg::t2ar_data_t bus_rdata, // Read data
  input wire logic trigger_input_pin, // Trigger pin
  input wire logic irq // Interrupt
);
  import t2ar_pkg::*;
  logic [1:0] mask_ff;
  logic [1:0] ctrl_ff;
  logic [3:0] mode_ff;
  t2ar_data_t reload_ff;

  // Shadow of software-only fields
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_ff <= 2'h0;
      ctrl_ff <= 2'h0;
      mode_ff <= 4'h0;
      reload_ff <= 16'h0000;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        4'h0: ctrl_ff <= bus_req.wdata[2:1];
        4'h1: mode_ff <= bus_req.wdata[3:0];
        4'h2: reload_ff <= bus_req.wdata;
        4'h5: mask_ff <= bus_req.wdata[1:0];
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_trig_edge;
    $past(arst_n) && !bus_req.wr &&
    trigger_input_pin != $past(trigger_input_pin) &&
    trigger_input_pin == mode_ff[1];
  endsequence

  sequence s_ext_armed;
    s_trig_edge ##0 (ctrl_ff == 2'b10 && mask_ff[1]);
  endsequence

  a_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == 16'h0000)
    else $error("read data not zero when idle");
  a_unmapped_rd: assert property (
    bus_req.rd && bus_req.addr > 4'h6 |=> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_reload_rd: assert property (
    bus_req.rd && bus_req.addr == 4'h2 |=> bus_rdata == reload_ff)
    else $error("reload read mismatch");
  a_mode_rd: assert property (
    bus_req.rd && bus_req.addr == 4'h1 |=> bus_rdata == {12'h000, mode_ff})
    else $error("mode read mismatch");
  a_mask_gate: assert property (irq |-> mask_ff != 2'h0)
    else $error("irq with all sources masked");
  a_mask_off: assert property (
    bus_req.wr && bus_req.addr == 4'h5 && bus_req.wdata[1:0] == 2'h0
    |=> !irq)
    else $error("irq after masking all");
  a_flag_sticky: assert property (
    irq && !(bus_req.wr && bus_req.addr inside {4'h4, 4'h5}) |=> irq)
    else $error("irq dropped without software clear");
  a_ext_reload: assert property (s_ext_armed |=> irq)
    else $error("pin edge did not raise irq");
endmodule

bind t2ar_timer t2ar_timer_chk chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .bus_req(bus_req), .bus_rdata(bus_rdata),
  .trigger_input_pin(trigger_input_pin), .irq(irq));

`default_nettype wire

// [sim/t2ar_trig_src.sv]
// Trigger pin source: drives the pin in step with the clock.
// Assumes one caller at a time; hold sets a prompt or slow pace.
`timescale 1ns/1ns
`default_nettype none

module t2ar_trig_src (
  input wire logic sys_clk, // Clock
  output logic pin // Trigger pin level
);
  initial pin = 1'b0;

  // New level just after an edge, held for hold cycles
  task automatic drive(input logic lvl, input int hold);
    @(posedge sys_clk);
    pin <= lvl;
    repeat (hold) @(posedge sys_clk);
  endtask
endmodule

`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the auto-reload timer.
// Assumes the checker is attached by its own bind.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; \
  if ((got) !== (exp)) begin fail_count++; \
  $display("ERROR %s exp %h got %h", nm, exp, got); end end

module tb_top;
  import t2ar_pkg::*;
  logic sys_clk, arst_n, trig, irq;
  t2ar_bus_req_s req;
  t2ar_data_t rdata, d;
  int fail_count, n_checks, n;

  t2ar_timer uut (.sys_clk(sys_clk), .arst_n(arst_n), .bus_req(req),
    .bus_rdata(rdata), .trigger_input_pin(trig), .irq(irq));
  t2ar_trig_src src (.sys_clk(sys_clk), .pin(trig));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic wr(input t2ar_addr_t a, input t2ar_data_t v);
    @(posedge sys_clk);
    req <= {a, v, 2'b10};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input t2ar_addr_t a, output t2ar_data_t v);
    @(posedge sys_clk);
    req <= {a, 16'h0000, 2'b01};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic chk_rd(input string nm, input t2ar_addr_t a,
                        input t2ar_data_t e);
    rd(a, d);
    `CHK(nm, e, d)
  endtask

  task automatic t_reset;
    `CHK("irq", 1'b0, irq)
    for (int a = 0; a < 16; a++) chk_rd("reset", 4'(a), 16'h0000);
  endtask

  task automatic t_overflow;
    wr(4'h1, 16'h0000); // Up/down off, pin held low
    wr(4'h2, 16'h1234);
    chk_rd("reload", 4'h2, 16'h1234);
    wr(4'h3, 16'hFFFE);
    wr(4'h5, 16'h0001);
    wr(4'h0, 16'h0001);
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    `CHK("ovf cycles", 24, n)
    chk_rd("count", 4'h3, 16'h1234);
    chk_rd("status", 4'h4, 16'h0001);
    wr(4'h5, 16'h0000);
    #1;
    `CHK("irq masked", 1'b0, irq)
    wr(4'h5, 16'h0001);
    #1;
    `CHK("irq unmasked", 1'b1, irq)
    wr(4'h4, 16'h0001);
    #1;
    `CHK("irq cleared", 1'b0, irq)
    rd(4'h6, d);
    `CHK("running", 1'b1, d[0])
    wr(4'h0, 16'h0000);
    rd(4'h3, d);
    repeat (30) @(posedge sys_clk);
    chk_rd("held", 4'h3, d);
  endtask

  task automatic t_pin_reload;
    wr(4'h1, 16'h0002);
    wr(4'h2, 16'h0100);
    wr(4'h3, 16'h0500);
    wr(4'h5, 16'h0002);
    wr(4'h0, 16'h0004); // Pin reloads on, stopped
    src.drive(1'b1, 1);
    #1;
    `CHK("irq ext", 1'b1, irq)
    chk_rd("dummy reload", 4'h3, 16'h0100);
    chk_rd("ext flag", 4'h4, 16'h0002);
    wr(4'h4, 16'h0002);
    wr(4'h3, 16'h0500);
    src.drive(1'b0, 3);
    chk_rd("wrong edge", 4'h3, 16'h0500);
    wr(4'h0, 16'h0006);
    src.drive(1'b1, 1);
    chk_rd("cp sel", 4'h3, 16'h0500);
    chk_rd("no flag", 4'h4, 16'h0000);
  endtask

  task automatic t_hw_start;
    wr(4'h0, 16'h0004);
    wr(4'h1, 16'h000E); // Start and reload on rising edges
    chk_rd("mode", 4'h1, 16'h000E);
    src.drive(1'b0, 1);
    src.drive(1'b1, 1);
    chk_rd("no reload at start", 4'h3, 16'h0500);
    chk_rd("start flag", 4'h4, 16'h0002);
    rd(4'h6, d);
    `CHK("hw run", 1'b1, d[0])
    wr(4'h4, 16'h0002);
    src.drive(1'b0, 2);
    src.drive(1'b1, 1);
    rd(4'h3, d);
    `CHK("later edge", 16'h0100, d)
    chk_rd("later flag", 4'h4, 16'h0002);
    rd(4'h6, d);
    `CHK("still run", 1'b1, d[0])
    wr(4'h0, 16'h0000);
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    arst_n = 1'b0;
    req = '0;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_overflow();
    t_pin_reload();
    t_hw_start();
    report_and_stop();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    report_and_stop();
  end
endmodule

`default_nettype wire
